// File: verilog/cdm_consts.vh
// Register offsets, field positions, reset values and step counts of the codec mode registers.
`ifndef CDM_CONSTS_VH
`define CDM_CONSTS_VH
`define CDM_ADDR_DAC_MOD 7'h44
`define CDM_ADDR_DAC_FLT 7'h45
`define CDM_ADDR_ADC_GL 7'h46
`define CDM_ADDR_ADC_GR 7'h47
`define CDM_ADDR_ADC_CLK 7'h48
`define CDM_RST_DAC_MOD 8'h00
`define CDM_RST_DAC_FLT 8'h00
`define CDM_RST_ADC_GAIN 8'hd7
`define CDM_RST_ADC_CLK 8'h00
`define CDM_RST_DAC_LEVEL 8'hff
`define CDM_MASK_DAC_MOD 8'h47
`define CDM_MASK_DAC_FLT 8'hf3
`define CDM_MASK_ADC_CLK 8'hf0
`define CDM_BIT_OVER 6
`define CDM_BIT_INVERT 2
`define CDM_BIT_MUTE_R 1
`define CDM_BIT_MUTE_L 0
`define CDM_BIT_ROLLOFF 7
`define CDM_BIT_DEEMPH_HI 6
`define CDM_BIT_DEEMPH_LO 5
`define CDM_BIT_DEEMPH_EN 4
`define CDM_BIT_ZPOL 1
`define CDM_BIT_ZCOMB 0
`define CDM_BIT_CSEL 7
`define CDM_BIT_ROLE_HI 6
`define CDM_BIT_ROLE_LO 4
`define CDM_DAC_MUTE_CODE 8'h00
`define CDM_ADC_MUTE_MAX 8'h0e
`define CDM_STEP_FS 3'h7
`define CDM_TIMEOUT_FS 10'h1ff
`define CDM_OSR_BASE 8'h40
`define CDM_ROLE_SLAVE 3'h0
`define CDM_ROLE_768 3'h1
`define CDM_ROLE_512 3'h2
`define CDM_ROLE_384 3'h3
`define CDM_ROLE_256 3'h4
`define CDM_HALF_768 4'h6
`define CDM_HALF_512 4'h4
`define CDM_HALF_384 4'h3
`define CDM_HALF_256 4'h2
`endif

// File: verilog/cdm_ramp.v
// Stepping attenuator level with a single-entry command buffer.
`timescale 1ns/1ps
`include "cdm_consts.vh"
module cdm_ramp #(
  parameter [7:0] RST_LEVEL = 8'hd7
) (
  // Clock and reset.
  input wire i_clk,
  input wire i_arst_n,
  // New target and step enable.
  input wire i_load,
  input wire [7:0] i_load_val,
  input wire i_step,
  // Current level and ramp activity.
  output wire [7:0] o_level,
  output wire o_busy
);
  reg [7:0] level_ff; // Level applied to the signal right now.
  reg [7:0] goal_ff; // Target of the ramp in progress.
  reg [7:0] pend_ff; // Command waiting for the ramp to finish.
  reg pend_vld_ff; // The waiting command is valid.
  wire busy = (level_ff != goal_ff);

  // A target written mid-ramp waits; a later one overwrites it, so only the last survives.
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      level_ff <= RST_LEVEL;
      goal_ff <= RST_LEVEL;
      pend_ff <= RST_LEVEL;
      pend_vld_ff <= 1'b0;
    end
    else
    begin
      if (i_load && busy)
      begin
        pend_ff <= i_load_val; // [R16]
        pend_vld_ff <= 1'b1;
      end
      else if (i_load)
      begin
        goal_ff <= i_load_val;
        pend_vld_ff <= 1'b0;
      end
      else if (!busy && pend_vld_ff)
      begin
        goal_ff <= pend_ff; // [R16]
        pend_vld_ff <= 1'b0;
      end
      // One code is one 0.5 dB step, so each enable while level and goal differ moves the level one code.
      if (i_step && busy)
      begin
        if (level_ff < goal_ff)
          level_ff <= level_ff + 8'h01; // [R14]
        else
          level_ff <= level_ff - 8'h01; // [R14]
      end
    end
  end

  assign o_level = level_ff;
  assign o_busy = busy | pend_vld_ff;
endmodule // cdm_ramp

// File: verilog/cdm_mode_regs.v
// Codec DAC and ADC mode registers with attenuator ramps and ADC clock control.
//
// Function
// [R1] DAC oversampling follows clock ratio, bit doubles.
// [R2] Software avoids changing oversampling during operation.
// [R3] Phase bit inverts both DAC outputs.
// [R4] Separate left and right DAC soft-mute bits.
// [R5] Mute ramps DAC down, step per 8 samples.
// [R6] Unmute ramps DAC back to programmed level.
// [R7] Roll-off bit: clear sharp, set slow.
// [R8] De-emphasis rate field: 44.1, 48, 32 kHz.
// [R9] De-emphasis enable bit, default bypassed.
// [R10] Polarity bit sets silence flags active level.
// [R11] Combine bit makes both flags report both.
// [R12] ADC gain is half dB per code offset.
// [R13] ADC gain levels reset to unity code.
// [R14] ADC gain steps at zero crossings or 8 samples.
// [R15] No crossing for 512 samples: step every sample.
// [R16] Mid-ramp writes buffered, last one runs afterwards.
// [R17] Clock-set bit picks first or second clock set.
// [R18] Role field selects slave or master ratio.
// [R19] Zero-cross disable picks crossing or fixed stepping.
// [R20] Software never writes reserved codes or bits.
// [R21] Master mode generates bit and frame clocks.
`timescale 1ns/1ps
`include "cdm_consts.vh"
module cdm_mode_regs (
  // Clock and reset.
  input wire I_SYS_CLK,
  input wire I_ARST_N,
  // Register access, address and data as carried by the control port.
  input wire I_REG_WR,
  input wire I_REG_RD,
  input wire [6:0] I_REG_ADDR,
  input wire [7:0] I_REG_WDATA,
  output reg [7:0] O_REG_RDATA,
  // Sample-rate timebase, one pulse per sample period.
  input wire I_FS_TICK,
  // DAC side status and settings from outside this slice.
  input wire [1:0] I_DAC_CLK_RATIO,
  input wire [7:0] I_DAC_LEFT_LEVEL,
  input wire [7:0] I_DAC_RIGHT_LEVEL,
  input wire I_LEFT_ZERO_DATA,
  input wire I_RIGHT_ZERO_DATA,
  // ADC side status and settings from outside this slice.
  input wire I_ZERO_CROSS_DISABLE,
  input wire I_ADC_LEFT_ZERO_CROSS,
  input wire I_ADC_RIGHT_ZERO_CROSS,
  // Audio clock inputs of both clock sets.
  input wire I_SYSCLK_IN_A,
  input wire I_BITCLK_A,
  input wire I_FRAMECLK_A,
  input wire I_SYSCLK_IN_B,
  input wire I_BITCLK_B,
  input wire I_FRAMECLK_B,
  // DAC controls.
  output reg [7:0] O_DAC_OSR,
  output reg O_DAC_OUTPUT_INVERT,
  output reg O_DAC_ROLLOFF_SEL,
  output reg [1:0] O_DEEMPH_RATE_SEL,
  output reg O_DEEMPH_ENABLE,
  output reg [7:0] O_DAC_LEFT_ATTEN,
  output reg [7:0] O_DAC_RIGHT_ATTEN,
  output reg O_LEFT_SILENCE_FLAG,
  output reg O_RIGHT_SILENCE_FLAG,
  // ADC controls.
  output reg [7:0] O_ADC_LEFT_GAIN,
  output reg [7:0] O_ADC_RIGHT_GAIN,
  output reg O_ADC_LEFT_MUTE,
  output reg O_ADC_RIGHT_MUTE,
  output reg O_ADC_CLOCK_SET_SEL,
  output reg O_ADC_MASTER,
  output reg O_ADC_SYSCLK,
  output reg O_ADC_BITCLK,
  output reg O_ADC_FRAMECLK
);
  // Stored register contents, reserved bits always zero.
  reg [7:0] dac_mod_ff;
  reg [7:0] dac_flt_ff;
  reg [7:0] adc_gl_ff;
  reg [7:0] adc_gr_ff;
  reg [7:0] adc_clk_ff;
  // Sample-period divider for the fixed eight-sample step.
  reg [2:0] fs_cnt_ff;
  // DAC ramp goals as last handed to the ramps.
  reg [7:0] dac_goal_l_ff;
  reg [7:0] dac_goal_r_ff;
  // Master clock generator state.
  reg sck_prev_ff;
  reg [3:0] half_cnt_ff;
  reg gen_bck_ff;
  reg [5:0] bit_cnt_ff;
  // Ramp interface wires.
  wire [7:0] lvl [0:3];
  wire [3:0] load;
  wire [7:0] load_val [0:3];
  wire [3:0] step;
  wire eight_tick = I_FS_TICK && (fs_cnt_ff == `CDM_STEP_FS);
  wire [1:0] zc = {I_ADC_RIGHT_ZERO_CROSS, I_ADC_LEFT_ZERO_CROSS};
  wire [1:0] timeout;
  wire [7:0] nxt_goal_l;
  wire [7:0] nxt_goal_r;
  wire [2:0] role = adc_clk_ff[`CDM_BIT_ROLE_HI:`CDM_BIT_ROLE_LO];
  wire csel = adc_clk_ff[`CDM_BIT_CSEL];
  wire sel_sck = csel ? I_SYSCLK_IN_B : I_SYSCLK_IN_A;
  wire sel_bck = csel ? I_BITCLK_B : I_BITCLK_A;
  wire sel_lrck = csel ? I_FRAMECLK_B : I_FRAMECLK_A;
  wire master = (role != `CDM_ROLE_SLAVE);
  wire [3:0] half = role_half(role);
  wire sck_rise = sel_sck && !sck_prev_ff;
  // Half bit-clock period in system-clock edges for the master ratios at 64 bits a frame.
  function [3:0] role_half;
    input [2:0] r;
    begin
      case (r)
        `CDM_ROLE_768: role_half = `CDM_HALF_768;
        `CDM_ROLE_512: role_half = `CDM_HALF_512;
        `CDM_ROLE_384: role_half = `CDM_HALF_384;
        default: role_half = `CDM_HALF_256; // Role 256 and the reserved codes.
      endcase
    end
  endfunction
  // Codes at or below the mute ceiling give infinite attenuation.
  function adc_is_mute;
    input [7:0] code;
    begin
      adc_is_mute = (code <= `CDM_ADC_MUTE_MAX); // [R12]
    end
  endfunction
  // Register writes; reserved positions are masked so they read back as zero.
  always @(posedge I_SYS_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      dac_mod_ff <= `CDM_RST_DAC_MOD;
      dac_flt_ff <= `CDM_RST_DAC_FLT;
      adc_gl_ff <= `CDM_RST_ADC_GAIN; // [R13]
      adc_gr_ff <= `CDM_RST_ADC_GAIN; // [R13]
      adc_clk_ff <= `CDM_RST_ADC_CLK;
    end
    else if (I_REG_WR)
    begin
      case (I_REG_ADDR)
        `CDM_ADDR_DAC_MOD: dac_mod_ff <= I_REG_WDATA & `CDM_MASK_DAC_MOD;
        `CDM_ADDR_DAC_FLT: dac_flt_ff <= I_REG_WDATA & `CDM_MASK_DAC_FLT;
        `CDM_ADDR_ADC_GL: adc_gl_ff <= I_REG_WDATA;
        `CDM_ADDR_ADC_GR: adc_gr_ff <= I_REG_WDATA;
        `CDM_ADDR_ADC_CLK: adc_clk_ff <= I_REG_WDATA & `CDM_MASK_ADC_CLK;
        default: adc_clk_ff <= adc_clk_ff;
      endcase
    end
  end
  // Register reads are registered; an unmapped address returns zero.
  always @(posedge I_SYS_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      O_REG_RDATA <= 8'h00;
    else if (I_REG_RD)
    begin
      case (I_REG_ADDR)
        `CDM_ADDR_DAC_MOD: O_REG_RDATA <= dac_mod_ff;
        `CDM_ADDR_DAC_FLT: O_REG_RDATA <= dac_flt_ff;
        `CDM_ADDR_ADC_GL: O_REG_RDATA <= adc_gl_ff;
        `CDM_ADDR_ADC_GR: O_REG_RDATA <= adc_gr_ff;
        `CDM_ADDR_ADC_CLK: O_REG_RDATA <= adc_clk_ff;
        default: O_REG_RDATA <= 8'h00;
      endcase
    end
  end
  // Sample counter shared by every fixed eight-sample step.
  always @(posedge I_SYS_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      fs_cnt_ff <= 3'h0;
    else if (I_FS_TICK)
      fs_cnt_ff <= fs_cnt_ff + 3'h1;
  end
  // DAC goal is zero while muted, else the programmed attenuator level.
  assign nxt_goal_l = dac_mod_ff[`CDM_BIT_MUTE_L] ? `CDM_DAC_MUTE_CODE : I_DAC_LEFT_LEVEL; // [R4]
  assign nxt_goal_r = dac_mod_ff[`CDM_BIT_MUTE_R] ? `CDM_DAC_MUTE_CODE : I_DAC_RIGHT_LEVEL; // [R4]
  // Remember the goal last handed over so a change becomes a single load pulse.
  always @(posedge I_SYS_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      dac_goal_l_ff <= `CDM_RST_DAC_LEVEL;
      dac_goal_r_ff <= `CDM_RST_DAC_LEVEL;
    end
    else
    begin
      dac_goal_l_ff <= nxt_goal_l;
      dac_goal_r_ff <= nxt_goal_r;
    end
  end
  // Channels 0 and 1 are DAC left and right; they always step every eight samples.
  assign load[0] = (nxt_goal_l != dac_goal_l_ff); // [R5] [R6]
  assign load[1] = (nxt_goal_r != dac_goal_r_ff); // [R5] [R6]
  assign load_val[0] = nxt_goal_l;
  assign load_val[1] = nxt_goal_r;
  assign step[0] = eight_tick; // [R5] [R6]
  assign step[1] = eight_tick; // [R5] [R6]
  // Channels 2 and 3 are ADC left and right, loaded by their register writes.
  assign load[2] = I_REG_WR && (I_REG_ADDR == `CDM_ADDR_ADC_GL);
  assign load[3] = I_REG_WR && (I_REG_ADDR == `CDM_ADDR_ADC_GR);
  assign load_val[2] = I_REG_WDATA;
  assign load_val[3] = I_REG_WDATA;
  genvar g;
  // Zero-cross timeout per ADC channel; once expired it steps every sample until a crossing.
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_adc
      reg [9:0] quiet_cnt_ff;
      reg timeout_ff;
      always @(posedge I_SYS_CLK or negedge I_ARST_N)
      begin
        if (!I_ARST_N)
        begin
          quiet_cnt_ff <= 10'h000;
          timeout_ff <= 1'b0;
        end
        else if (I_FS_TICK)
        begin
          if (zc[g])
          begin
            quiet_cnt_ff <= 10'h000;
            timeout_ff <= 1'b0;
          end
          else if (quiet_cnt_ff == `CDM_TIMEOUT_FS)
            timeout_ff <= 1'b1; // [R15]
          else
            quiet_cnt_ff <= quiet_cnt_ff + 10'h001;
        end
      end
      assign timeout[g] = timeout_ff;
      // Crossings are sampled once per sample period; the disable bit selects fixed steps.
      assign step[g + 2] = I_ZERO_CROSS_DISABLE ? eight_tick :
                           (I_FS_TICK && (zc[g] || timeout_ff)); // [R14] [R15] [R19]
    end
  endgenerate
  // Four identical ramps; only reset level, load source and step source differ.
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_ramp
      cdm_ramp #(
        .RST_LEVEL((g < 2) ? `CDM_RST_DAC_LEVEL : `CDM_RST_ADC_GAIN)
      ) u_ramp (
        .i_clk(I_SYS_CLK),
        .i_arst_n(I_ARST_N),
        .i_load(load[g]),
        .i_load_val(load_val[g]),
        .i_step(step[g]),
        .o_level(lvl[g]),
        .o_busy()
      );
    end
  endgenerate
  // Master clock generator: bit clock from selected system clock, frame every 64 bits.
  always @(posedge I_SYS_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      sck_prev_ff <= 1'b0;
      half_cnt_ff <= 4'h0;
      gen_bck_ff <= 1'b0;
      bit_cnt_ff <= 6'h00;
    end
    else
    begin
      sck_prev_ff <= sel_sck;
      // Held in reset while slave so a new master mode starts from a clean frame.
      if (!master)
      begin
        half_cnt_ff <= 4'h0;
        gen_bck_ff <= 1'b0;
        bit_cnt_ff <= 6'h00;
      end
      else if (sck_rise)
      begin
        if (half_cnt_ff >= half - 4'h1)
        begin
          half_cnt_ff <= 4'h0;
          gen_bck_ff <= !gen_bck_ff; // [R21]
          if (gen_bck_ff)
            bit_cnt_ff <= bit_cnt_ff + 6'h01; // [R21]
        end
        else
          half_cnt_ff <= half_cnt_ff + 4'h1;
      end
    end
  end
  // Every output is registered; decodes settle one cycle after the register write.
  always @(posedge I_SYS_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      O_DAC_OSR <= `CDM_OSR_BASE;
      O_DAC_OUTPUT_INVERT <= 1'b0;
      O_DAC_ROLLOFF_SEL <= 1'b0;
      O_DEEMPH_RATE_SEL <= 2'h0;
      O_DEEMPH_ENABLE <= 1'b0;
      O_DAC_LEFT_ATTEN <= `CDM_RST_DAC_LEVEL;
      O_DAC_RIGHT_ATTEN <= `CDM_RST_DAC_LEVEL;
      O_LEFT_SILENCE_FLAG <= 1'b0;
      O_RIGHT_SILENCE_FLAG <= 1'b0;
      O_ADC_LEFT_GAIN <= `CDM_RST_ADC_GAIN;
      O_ADC_RIGHT_GAIN <= `CDM_RST_ADC_GAIN;
      O_ADC_LEFT_MUTE <= 1'b0;
      O_ADC_RIGHT_MUTE <= 1'b0;
      O_ADC_CLOCK_SET_SEL <= 1'b0;
      O_ADC_MASTER <= 1'b0;
      O_ADC_SYSCLK <= 1'b0;
      O_ADC_BITCLK <= 1'b0;
      O_ADC_FRAMECLK <= 1'b0;
    end
    else
    begin
      // Ratio 0 is 512/768, 1 is 256/384, 2 is 128/192; the bit doubles the rate.
      O_DAC_OSR <= (`CDM_OSR_BASE >> I_DAC_CLK_RATIO) << dac_mod_ff[`CDM_BIT_OVER]; // [R1]
      O_DAC_OUTPUT_INVERT <= dac_mod_ff[`CDM_BIT_INVERT]; // [R3]
      O_DAC_ROLLOFF_SEL <= dac_flt_ff[`CDM_BIT_ROLLOFF]; // [R7]
      O_DEEMPH_RATE_SEL <= dac_flt_ff[`CDM_BIT_DEEMPH_HI:`CDM_BIT_DEEMPH_LO]; // [R8]
      O_DEEMPH_ENABLE <= dac_flt_ff[`CDM_BIT_DEEMPH_EN]; // [R9]
      O_DAC_LEFT_ATTEN <= lvl[0];
      O_DAC_RIGHT_ATTEN <= lvl[1];
      // Combine first, then apply the polarity choice.
      O_LEFT_SILENCE_FLAG <= dac_flt_ff[`CDM_BIT_ZPOL] ^ (dac_flt_ff[`CDM_BIT_ZCOMB] ?
        (I_LEFT_ZERO_DATA & I_RIGHT_ZERO_DATA) : I_LEFT_ZERO_DATA); // [R10] [R11]
      O_RIGHT_SILENCE_FLAG <= dac_flt_ff[`CDM_BIT_ZPOL] ^ (dac_flt_ff[`CDM_BIT_ZCOMB] ?
        (I_LEFT_ZERO_DATA & I_RIGHT_ZERO_DATA) : I_RIGHT_ZERO_DATA); // [R10] [R11]
      O_ADC_LEFT_GAIN <= lvl[2]; // [R12]
      O_ADC_RIGHT_GAIN <= lvl[3]; // [R12]
      O_ADC_LEFT_MUTE <= adc_is_mute(lvl[2]); // [R12]
      O_ADC_RIGHT_MUTE <= adc_is_mute(lvl[3]); // [R12]
      O_ADC_CLOCK_SET_SEL <= csel; // [R17]
      O_ADC_MASTER <= master; // [R18]
      O_ADC_SYSCLK <= sel_sck; // [R17]
      // Slave passes the chosen set through; master drives generated clocks.
      O_ADC_BITCLK <= master ? gen_bck_ff : sel_bck; // [R17] [R21]
      O_ADC_FRAMECLK <= master ? !bit_cnt_ff[5] : sel_lrck; // [R17] [R21]
    end
  end
endmodule // cdm_mode_regs

// File: testbench/cdm_mode_regs_sva.sv
// Concurrent checks on the ports of the codec mode register block.
`timescale 1ns/1ps
module cdm_mode_regs_sva (
  // Clock, reset and the inputs that cause the watched behaviour.
  input wire I_SYS_CLK,
  input wire I_ARST_N,
  input wire I_REG_WR,
  input wire [6:0] I_REG_ADDR,
  input wire [7:0] I_REG_WDATA,
  input wire I_FS_TICK,
  input wire [1:0] I_DAC_CLK_RATIO,
  input wire I_BITCLK_A,
  input wire I_BITCLK_B,
  // Outputs under watch.
  input wire [7:0] O_DAC_OSR,
  input wire O_DAC_OUTPUT_INVERT,
  input wire [7:0] O_DAC_LEFT_ATTEN,
  input wire [7:0] O_ADC_LEFT_GAIN,
  input wire O_ADC_LEFT_MUTE,
  input wire O_ADC_CLOCK_SET_SEL,
  input wire O_ADC_MASTER,
  input wire O_ADC_BITCLK
);
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_ARST_N);
  // Two edges after a write the phase bit must show, whichever edge registers it.
  a_invert_after_write: assert property (I_REG_WR && I_REG_ADDR == 7'h44 |-> ##2
    O_DAC_OUTPUT_INVERT == (($past(I_REG_WDATA, 2) & 8'h04) != 8'h00))
    else $error("phase bit did not follow the write");
  a_osr_after_write: assert property (I_REG_WR && I_REG_ADDR == 7'h44 |-> ##2
    O_DAC_OSR == ((8'h40 >> $past(I_DAC_CLK_RATIO)) <<
      (($past(I_REG_WDATA, 2) & 8'h40) != 8'h00)))
    else $error("oversampling factor wrong");
  // Ramps move one half-decibel code at a time.
  a_dac_one_step: assert property ($changed(O_DAC_LEFT_ATTEN) |->
    (O_DAC_LEFT_ATTEN - $past(O_DAC_LEFT_ATTEN) == 8'h01) ||
    ($past(O_DAC_LEFT_ATTEN) - O_DAC_LEFT_ATTEN == 8'h01))
    else $error("DAC ramp jumped");
  a_dac_step_gap: assert property ($changed(O_DAC_LEFT_ATTEN) |=>
    $stable(O_DAC_LEFT_ATTEN) [*8])
    else $error("DAC ramp stepped too soon");
  a_adc_one_step: assert property ($changed(O_ADC_LEFT_GAIN) |->
    (O_ADC_LEFT_GAIN - $past(O_ADC_LEFT_GAIN) == 8'h01) ||
    ($past(O_ADC_LEFT_GAIN) - O_ADC_LEFT_GAIN == 8'h01))
    else $error("ADC ramp jumped");
  a_adc_on_tick: assert property ($changed(O_ADC_LEFT_GAIN) |->
    $past(I_FS_TICK) || $past(I_FS_TICK, 2) || $past(I_FS_TICK, 3))
    else $error("ADC ramp stepped off the sample tick");
  // The mute flag follows a settled gain code.
  a_adc_mute_code: assert property ($stable(O_ADC_LEFT_GAIN) &&
    $past(O_ADC_LEFT_GAIN, 2) == O_ADC_LEFT_GAIN |->
    O_ADC_LEFT_MUTE == (O_ADC_LEFT_GAIN <= 8'h0e))
    else $error("ADC mute flag disagrees with gain");
  // In slave mode the chosen set's bit clock is passed through.
  a_slave_route: assert property ($past(I_ARST_N) && !O_ADC_MASTER &&
    !$past(O_ADC_MASTER) && $stable(O_ADC_CLOCK_SET_SEL) |->
    O_ADC_BITCLK == (O_ADC_CLOCK_SET_SEL ? $past(I_BITCLK_B) : $past(I_BITCLK_A)))
    else $error("bit clock not routed from the chosen set");
  c_dac_ramp: cover property ($changed(O_DAC_LEFT_ATTEN));
  c_adc_mute: cover property ($rose(O_ADC_LEFT_MUTE));
  c_master: cover property ($rose(O_ADC_MASTER));
endmodule // cdm_mode_regs_sva

bind cdm_mode_regs cdm_mode_regs_sva u_sva (.*);

// File: testbench/cdm_mode_regs_bench.sv
// Self-checking bench for the codec mode register block.
`timescale 1ns/1ps
`include "cdm_consts.vh"
module cdm_mode_regs_bench;
  // Design inputs, all driven at the falling edge.
  reg I_SYS_CLK = 1'b0;
  reg I_ARST_N = 1'b0;
  reg I_REG_WR = 1'b0, I_REG_RD = 1'b0, I_FS_TICK = 1'b0;
  reg [6:0] I_REG_ADDR = 7'h00;
  reg [7:0] I_REG_WDATA = 8'h00, I_DAC_LEFT_LEVEL = 8'hff, I_DAC_RIGHT_LEVEL = 8'hff;
  reg [1:0] I_DAC_CLK_RATIO = 2'h0;
  reg I_LEFT_ZERO_DATA = 1'b0, I_RIGHT_ZERO_DATA = 1'b0, I_ZERO_CROSS_DISABLE = 1'b0;
  reg I_ADC_LEFT_ZERO_CROSS = 1'b0, I_ADC_RIGHT_ZERO_CROSS = 1'b0;
  reg I_SYSCLK_IN_A = 1'b0, I_BITCLK_A = 1'b0, I_FRAMECLK_A = 1'b0;
  reg I_SYSCLK_IN_B = 1'b0, I_BITCLK_B = 1'b0, I_FRAMECLK_B = 1'b0;
  // Design outputs.
  wire [7:0] O_REG_RDATA, O_DAC_OSR, O_DAC_LEFT_ATTEN, O_DAC_RIGHT_ATTEN;
  wire [7:0] O_ADC_LEFT_GAIN, O_ADC_RIGHT_GAIN;
  wire [1:0] O_DEEMPH_RATE_SEL;
  wire O_DAC_OUTPUT_INVERT, O_DAC_ROLLOFF_SEL, O_DEEMPH_ENABLE, O_LEFT_SILENCE_FLAG;
  wire O_RIGHT_SILENCE_FLAG, O_ADC_LEFT_MUTE, O_ADC_RIGHT_MUTE, O_ADC_CLOCK_SET_SEL;
  wire O_ADC_MASTER, O_ADC_SYSCLK, O_ADC_BITCLK, O_ADC_FRAMECLK;
  // Bench state; the pattern register keeps clock inputs off the random stream.
  integer seed = 32'h7729;
  integer n_mismatch = 0, comparisons = 0, cyc = 0, t0, n, i, j;
  reg [7:0] d;
  reg [3:0] pat = 4'h0;
  cdm_mode_regs DUT (.*);
  always #20 I_SYS_CLK = ~I_SYS_CLK;
  always @(posedge I_SYS_CLK) cyc <= cyc + 1;
  // Sample tick every fourth cycle; audio system clocks toggle each cycle.
  always @(negedge I_SYS_CLK)
  begin
    I_FS_TICK <= (cyc % 4 == 0);
    I_SYSCLK_IN_A <= ~I_SYSCLK_IN_A;
    I_SYSCLK_IN_B <= I_SYSCLK_IN_A;
    pat <= pat * 4'h5 + 4'h3;
    {I_BITCLK_A, I_FRAMECLK_A, I_BITCLK_B, I_FRAMECLK_B} <= pat;
  end
  // Counts every comparison and reports a mismatch at once.
  task chk(input [7:0] seen, input [7:0] exp);
  begin
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  // Write strobe of one cycle, then one idle cycle so outputs settle.
  task wr(input [6:0] a, input [7:0] v);
  begin
    @(negedge I_SYS_CLK);
    I_REG_WR = 1'b1;
    I_REG_ADDR = a;
    I_REG_WDATA = v;
    @(negedge I_SYS_CLK);
    I_REG_WR = 1'b0;
    @(negedge I_SYS_CLK);
  end
  endtask
  // Read data is registered, so it is looked at one cycle after the strobe.
  task rd(input [6:0] a, input [7:0] e);
  begin
    @(negedge I_SYS_CLK);
    I_REG_RD = 1'b1;
    I_REG_ADDR = a;
    @(negedge I_SYS_CLK);
    I_REG_RD = 1'b0;
    chk(O_REG_RDATA, e);
  end
  endtask
  function [7:0] lvl(input integer w);
    lvl = (w == 0) ? O_ADC_LEFT_GAIN : (w == 1) ? O_ADC_RIGHT_GAIN : O_DAC_LEFT_ATTEN;
  endfunction
  // Bounded wait for a ramp level.
  task wait_lvl(input integer w, input [7:0] v);
  begin
    n = 0;
    while (lvl(w) !== v && n < 9000)
    begin
      @(negedge I_SYS_CLK);
      n = n + 1;
    end
  end
  endtask
  function integer half(input integer r);
    half = (r == 1) ? 6 : (r == 2) ? 4 : (r == 3) ? 3 : 2;
  endfunction
  function [7:0] msk(input integer a);
    msk = (a == 0) ? `CDM_MASK_DAC_MOD : (a == 1) ? `CDM_MASK_DAC_FLT :
      (a == 4) ? `CDM_MASK_ADC_CLK : 8'hff;
  endfunction
  task final_report;
  begin
    if (n_mismatch == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  // Main sequence.
  initial
  begin
    repeat (4) @(negedge I_SYS_CLK);
    I_ARST_N = 1'b1;
    chk(O_ADC_LEFT_GAIN, 8'hd7);
    rd(7'h44, 8'h00);
    rd(7'h45, 8'h00);
    rd(7'h46, 8'hd7);
    rd(7'h47, 8'hd7);
    rd(7'h48, 8'h00);
    wr(7'h43, 8'hff);
    rd(7'h43, 8'h00);
    for (i = 0; i < 6; i = i + 1)
    begin
      d = $random(seed);
      I_DAC_CLK_RATIO = i[2:1];
      wr(7'h44, {1'b0, i[0], 3'h0, d[2], 2'h0});
      chk(O_DAC_OSR, (8'h40 >> i[2:1]) << i[0]);
      chk(O_DAC_OUTPUT_INVERT, d[2]);
    end
    for (i = 0; i < 3; i = i + 1)
    begin
      d = $random(seed);
      wr(7'h45, {d[7], i[1:0], d[4], 4'h0});
      chk(O_DEEMPH_RATE_SEL, i[1:0]);
      chk(O_DAC_ROLLOFF_SEL, d[7]);
      chk(O_DEEMPH_ENABLE, d[4]);
    end
    // Every polarity and combine setting against every zero pattern.
    for (i = 0; i < 16; i = i + 1)
    begin
      {I_LEFT_ZERO_DATA, I_RIGHT_ZERO_DATA} = i[1:0];
      wr(7'h45, {6'h00, i[3:2]});
      repeat (2) @(negedge I_SYS_CLK);
      chk(O_LEFT_SILENCE_FLAG, (i[2] ? i[1] & i[0] : i[1]) ^ i[3]);
      chk(O_RIGHT_SILENCE_FLAG, (i[2] ? i[1] & i[0] : i[0]) ^ i[3]);
    end
    // Each role; a system clock rise comes every second cycle, so bit clock toggles every 2*half.
    for (i = 0; i < 5; i = i + 1)
    begin
      d = $random(seed);
      wr(7'h48, {d[0], i[2:0], 4'h0});
      chk(O_ADC_MASTER, i != 0);
      chk(O_ADC_CLOCK_SET_SEL, d[0]);
      if (i != 0)
      begin
        repeat (8) @(negedge I_SYS_CLK);
        n = 0;
        for (j = 0; j < 96; j = j + 1)
        begin
          d[1] = O_ADC_BITCLK;
          @(negedge I_SYS_CLK);
          n = n + (O_ADC_BITCLK != d[1]);
        end
        chk(n, 96 / (2 * half(i)));
      end
      else
      begin
        // Slave passes the chosen set's system and frame clocks with one cycle of delay.
        for (j = 0; j < 4; j = j + 1)
        begin
          @(negedge I_SYS_CLK);
          chk(O_ADC_SYSCLK, d[0] ? I_SYSCLK_IN_B : I_SYSCLK_IN_A);
          chk(O_ADC_FRAMECLK, d[0] ? I_FRAMECLK_B : I_FRAMECLK_A);
        end
      end
    end
    wr(7'h48, 8'h00);
    // Three crossings give three steps, then silence needs the timeout.
    wr(7'h47, 8'hd0);
    I_ADC_RIGHT_ZERO_CROSS = 1'b1;
    repeat (12) @(negedge I_SYS_CLK);
    I_ADC_RIGHT_ZERO_CROSS = 1'b0;
    repeat (3) @(negedge I_SYS_CLK);
    chk(O_ADC_RIGHT_GAIN, 8'hd4);
    repeat (1600) @(negedge I_SYS_CLK);
    chk(O_ADC_RIGHT_GAIN, 8'hd4);
    repeat (520) @(negedge I_SYS_CLK);
    chk(O_ADC_RIGHT_GAIN, 8'hd0);
    chk(O_ADC_RIGHT_MUTE, 1'b0);
    // Fixed stepping down to the first mute code.
    I_ZERO_CROSS_DISABLE = 1'b1;
    t0 = cyc;
    wr(7'h46, 8'h0e);
    wait_lvl(0, 8'h0f);
    repeat (3) @(negedge I_SYS_CLK);
    chk(O_ADC_LEFT_MUTE, 1'b0);
    wait_lvl(0, 8'h0e);
    chk(cyc - t0 >= 6400 && cyc - t0 <= 6440, 1'b1);
    repeat (3) @(negedge I_SYS_CLK);
    chk(O_ADC_LEFT_MUTE, 1'b1);
    // Writes during a ramp: only the last one runs afterwards.
    wr(7'h46, 8'h1e);
    wr(7'h46, 8'h40);
    wr(7'h46, 8'h10);
    wait_lvl(0, 8'h1e);
    repeat (40) @(negedge I_SYS_CLK);
    chk(O_ADC_LEFT_GAIN, 8'h1d);
    wait_lvl(0, 8'h10);
    repeat (64) @(negedge I_SYS_CLK);
    chk(O_ADC_LEFT_GAIN, 8'h10);
    // Left soft mute all the way down and back; right must not move.
    t0 = cyc;
    wr(7'h44, 8'h01);
    wait_lvl(2, 8'h00);
    chk(cyc - t0 >= 8128 && cyc - t0 <= 8172, 1'b1);
    chk(O_DAC_RIGHT_ATTEN, 8'hff);
    // A level programmed while muted is where the unmute ramp must end.
    I_DAC_LEFT_LEVEL = 8'hf0;
    t0 = cyc;
    wr(7'h44, 8'h00);
    wait_lvl(2, 8'hf0);
    chk(O_DAC_LEFT_ATTEN, 8'hf0);
    chk(cyc - t0 >= 7648 && cyc - t0 <= 7692, 1'b1);
    // Random readback; reserved codes and bits are kept out, and oversampling stays put.
    for (i = 0; i < 20; i = i + 1)
    begin
      j = {$random(seed)} % 5;
      d = $random(seed) & msk(j);
      if (j != 2 && j != 3)
        d[6] = 1'b0;
      wr(7'h44 + j[6:0], d);
      rd(7'h44 + j[6:0], d);
    end
    final_report;
  end
  // Watchdog well beyond the expected run length.
  initial
  begin
    #(40 * 60000);
    n_mismatch = n_mismatch + 1;
    final_report;
  end
endmodule // cdm_mode_regs_bench
